// File: src/tts_pkg.sv
/*
  Shared constants for the time-of-use tariff scheduler: register offsets,
  field positions, reset values and FSM states.
  Assumes a single 10 MHz clock domain and a plain register port.
*/
package tts_pkg;
  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int NREG  = 4;
  localparam int NCAL  = 32;
  localparam int NPT   = 8;
  localparam int NPRO  = 128;
  localparam int NLOG  = 3;
  localparam int NTRF  = 8;
  localparam int CFG_W = 12;
  localparam int CAL_W = 32;
  localparam int PRO_W = 11;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] A_CFG  = 8'h00;
  localparam logic [7:0] A_MULT = 8'h04;
  localparam logic [7:0] A_LOG  = 8'h08;
  localparam logic [7:0] A_STAT = 8'h0C;
  localparam logic [2:0] A_CAL3 = 3'h2;

  // ----------------------------------------------------------------
  // Register configuration fields
  // ----------------------------------------------------------------
  localparam int F_TOU  = 0;
  localparam int F_USE  = 1;
  localparam int F_DMD  = 2;
  localparam int F_SUM  = 3;
  localparam int F_SRC  = 4;
  localparam int F_UNIT = 9;
  localparam int F_TGT  = 12;
  localparam logic [CFG_W-1:0] CFG_RST = 12'h00A;
  localparam logic [4:0] SRC_NONE = 5'h00;
  localparam logic [4:0] SRC_KVAH = 5'h05;
  localparam logic [4:0] SRC_DI1  = 5'h06;
  localparam logic [4:0] SRC_MAX  = 5'h11;
  localparam logic [2:0] U_NONE  = 3'h0;
  localparam logic [2:0] U_KWH   = 3'h1;
  localparam logic [2:0] U_KVARH = 3'h2;
  localparam logic [2:0] U_KVAH  = 3'h3;

  // ----------------------------------------------------------------
  // Multiplier in thousandths, log memory in bytes
  // ----------------------------------------------------------------
  localparam logic [16:0] MULT_MIN = 17'h00001;
  localparam logic [16:0] MULT_MAX = 17'h186A0;
  localparam logic [16:0] MULT_DEF = 17'h003E8;
  localparam logic [17:0] MEM_BYTES = 18'h1F400;
  localparam logic [16:0] LOG_EVT_DEF = 17'h00C80;
  localparam logic [16:0] LOG_D1_DEF  = 17'h19500;
  localparam logic [16:0] LOG_D2_DEF  = 17'h021C0;

  // ----------------------------------------------------------------
  // Calendar entry and change point fields
  // ----------------------------------------------------------------
  localparam int C_VAL = 26;
  localparam int C_SEA = 24;
  localparam int C_DAY = 22;
  localparam int C_WDS = 19;
  localparam int C_WDE = 16;
  localparam int C_MS  = 12;
  localparam int C_ME  = 8;
  localparam int C_MD  = 3;
  localparam int C_WK  = 0;
  localparam int P_VAL = 10;
  localparam int P_QTR = 3;
  localparam int P_TRF = 0;
  localparam logic [5:0] QTR_MIN = 6'h0F;

  typedef enum logic [1:0] {S_IDLE, S_CAL, S_PRO, S_SWEEP} tts_state_e;
endpackage

// File: src/tts_mem.sv
/*
  Small two-read-port memory with registered read data.
  Entries never written read as zero; assumes one clock and async reset.
*/
`timescale 1ns/1ps
module tts_mem #(
  parameter int W  = 32,
  parameter int D  = 32,
  parameter int AW = 5
) (
  input  wire logic          clk_sys_i,
  input  wire logic          reset_i,
  input  wire logic          we_i,
  input  wire logic [AW-1:0] waddr_i,
  input  wire logic [W-1:0]  wdata_i,
  input  wire logic [AW-1:0] ra_i,
  input  wire logic [AW-1:0] rb_i,
  output logic      [W-1:0]  qa_o,
  output logic      [W-1:0]  qb_o
);
  logic [W-1:0] mem_q [D];
  logic [D-1:0] vld_q;

  always_ff @(posedge clk_sys_i) begin
    if (we_i) begin
      mem_q[waddr_i] <= wdata_i;
    end
  end

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      vld_q <= '0;
      qa_o  <= '0;
      qb_o  <= '0;
    end else begin
      if (we_i) begin
        vld_q[waddr_i] <= 1'b1;
      end
      qa_o <= vld_q[ra_i] ? mem_q[ra_i] : '0;
      qb_o <= vld_q[rb_i] ? mem_q[rb_i] : '0;
    end
  end
endmodule

// File: src/tts_top.sv
/*
  Time-of-use tariff scheduler: billing register links, season calendar,
  daily tariff profiles and daily billing log selection.
  Assumes the device clock fields and energy pulses are synchronous to clk_sys_i.
*/
`timescale 1ns/1ps
// What this block does
// - TOU option links tariff registers to the register source; cleared after reset.
// - Energy profiling, default on, logs energy registers plus tariffs under TOU.
// - Demand profiling, default off, logs max demand totals plus tariffs under TOU.
// - Summary profiling, default on, logs total summary registers.
// - Unit is automatic for internal sources, user chosen for pulse inputs.
// - Source is none, five internal energies, or one of twelve pulse inputs.
// - Multiplier 0.001 to 100.000, default 1.000, fixed for internal sources.
// - Each configured source gets its target slot automatically.
// - Profiles use a 15 minute grid, 4 seasons by 4 day types.
// - First change point is 00:00; last one holds until midnight.
// - Log record width follows the count of tariffs used in profiles.
// - Calendar holds 32 entries of season, day type and validity window.
// - Weekday and month bounds may be given in either order.
// - Exception days match by month day or by week and weekday.
// - First matching calendar entry in stored order wins.
// - Unset month day or months match every day or month.
// - Log storage of 125 KByte is partitioned freely among files.
// - Exactly three log files: one event log, two data logs.
// - Factory sizes give a 15 minute profile log and a daily billing log.
// - Eight tariff rates and eight change points per day.
module tts_top (
  input  wire logic        clk_sys_i,
  input  wire logic        reset_i,
  input  wire logic [7:0]  addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [31:0] rdata_o,
  input  wire logic [3:0]  month_i,
  input  wire logic [4:0]  mday_i,
  input  wire logic [2:0]  wday_i,
  input  wire logic [2:0]  wom_i,
  input  wire logic [4:0]  hour_i,
  input  wire logic [5:0]  minute_i,
  input  wire logic [4:0]  energy_pulse_i,
  input  wire logic [11:0] pulse_digital_inputs_i,
  output logic      [3:0]  tot_pulse_o,
  output logic      [3:0]  tou_pulse_o,
  output logic      [2:0]  tariff_o,
  output logic      [1:0]  season_o,
  output logic      [1:0]  day_type_o,
  output logic      [3:0]  log_energy_o,
  output logic      [3:0]  log_demand_o,
  output logic      [3:0]  log_summary_o,
  output logic      [3:0]  log_tariffs_o
);
  // ----------------------------------------------------------------
  // Decoding helpers
  // ----------------------------------------------------------------
  function automatic logic [4:0] src_of(input logic [tts_pkg::CFG_W-1:0] c);
    return c[tts_pkg::F_SRC +: 5];
  endfunction

  function automatic logic is_int(input logic [4:0] s);
    return (s != tts_pkg::SRC_NONE) && (s <= tts_pkg::SRC_KVAH);
  endfunction

  function automatic logic [2:0] unit_of(input logic [tts_pkg::CFG_W-1:0] c);
    logic [4:0] s;
    s = src_of(c);
    if (s == tts_pkg::SRC_NONE) begin
      return tts_pkg::U_NONE;
    end else if (s < 5'h03) begin
      return tts_pkg::U_KWH;
    end else if (s < tts_pkg::SRC_KVAH) begin
      return tts_pkg::U_KVARH;
    end else if (s == tts_pkg::SRC_KVAH) begin
      return tts_pkg::U_KVAH;
    end
    return c[tts_pkg::F_UNIT +: 3];
  endfunction

  function automatic logic in_rng(input logic [3:0] v, input logic [3:0] a, input logic [3:0] b);
    return (a <= b) ? (v >= a && v <= b) : (v >= b && v <= a);
  endfunction

  function automatic logic cal_hit(input logic [31:0] e, input logic [3:0] mon, input logic [4:0] md,
                                   input logic [2:0] wd, input logic [2:0] wk);
    logic [3:0] ws;
    logic [3:0] we;
    logic [3:0] ms;
    logic [3:0] me;
    logic       okw;
    logic       okm;
    logic       okd;
    ws  = {1'b0, e[tts_pkg::C_WDS +: 3]};
    we  = {1'b0, e[tts_pkg::C_WDE +: 3]};
    ms  = e[tts_pkg::C_MS +: 4];
    me  = e[tts_pkg::C_ME +: 4];
    if (we == 4'h0) begin
      we = ws;
    end
    if (me == 4'h0) begin
      me = ms;
    end
    okw = (ws == 4'h0) || in_rng({1'b0, wd}, ws, we);
    okm = (ms == 4'h0) || in_rng(mon, ms, me);
    okd = ((e[tts_pkg::C_MD +: 5] == 5'h00) || (e[tts_pkg::C_MD +: 5] == md)) &&
          ((e[tts_pkg::C_WK +: 3] == 3'h0) || (e[tts_pkg::C_WK +: 3] == wk));
    return e[tts_pkg::C_VAL] && okw && okm && okd;
  endfunction

  function automatic logic [6:0] qtr_of(input logic [4:0] h, input logic [5:0] m);
    logic [1:0] q;
    q = (m >= 6'(3 * tts_pkg::QTR_MIN)) ? 2'h3 :
        (m >= 6'(2 * tts_pkg::QTR_MIN)) ? 2'h2 :
        (m >= tts_pkg::QTR_MIN) ? 2'h1 : 2'h0;
    return {h, q};
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [tts_pkg::CFG_W-1:0] cfg_q [tts_pkg::NREG];
  logic [tts_pkg::CFG_W-1:0] cfg_d [tts_pkg::NREG];
  logic [16:0]               mult_q [tts_pkg::NREG];
  logic [16:0]               mult_d [tts_pkg::NREG];
  logic [16:0]               log_q [tts_pkg::NLOG];
  logic [16:0]               log_d [tts_pkg::NLOG];
  logic [1:0]                tgt [tts_pkg::NREG];
  tts_pkg::tts_state_e       st_q;
  tts_pkg::tts_state_e       st_d;
  logic [6:0]                idx_q;
  logic [6:0]                idx_d;
  logic                      ph_q;
  logic                      ph_d;
  logic [1:0]                sea_q;
  logic [1:0]                sea_d;
  logic [1:0]                day_q;
  logic [1:0]                day_d;
  logic                      hit_q;
  logic                      hit_d;
  logic [2:0]                cand_q;
  logic [2:0]                cand_d;
  logic [2:0]                trf_q;
  logic [2:0]                trf_d;
  logic [7:0]                used_q;
  logic [7:0]                used_d;
  logic [3:0]                cnt_q;
  logic [3:0]                cnt_d;
  logic [6:0]                qtr_q;
  logic [6:0]                qtr_d;
  logic                      evp_q;
  logic                      evp_d;
  logic                      swp_q;
  logic                      swp_d;
  logic [31:0]               rd_q;
  logic [31:0]               rd_d;
  logic                      scal_q;
  logic                      scal_d;
  logic                      spro_q;
  logic                      spro_d;
  logic [3:0]                tot_d;
  logic [3:0]                tou_d;
  logic [3:0]                le_d;
  logic [3:0]                ld_d;
  logic [3:0]                ls_d;
  logic [3:0]                lt_d;
  logic                      cal_we;
  logic                      pro_we;
  logic [6:0]                qtr_now;
  logic [6:0]                pro_rb;
  logic [31:0]               cal_qa;
  logic [31:0]               cal_qb;
  logic [tts_pkg::PRO_W-1:0] pro_qa;
  logic [tts_pkg::PRO_W-1:0] pro_qb;

  assign cal_we  = wr_i && (addr_i[7:5] == tts_pkg::A_CAL3);
  assign pro_we  = wr_i && addr_i[7];
  assign qtr_now = qtr_of(hour_i, minute_i);
  assign pro_rb  = (st_q == tts_pkg::S_PRO) ? {sea_q, day_q, idx_q[2:0]} : idx_q;
  assign rdata_o = scal_q ? cal_qa : spro_q ? {21'h00000, pro_qa} : rd_q;

  // ----------------------------------------------------------------
  // Calendar and profile storage
  // ----------------------------------------------------------------
  tts_mem #(.W(tts_pkg::CAL_W), .D(tts_pkg::NCAL), .AW(5)) u_cal (
    .clk_sys_i (clk_sys_i),
    .reset_i   (reset_i),
    .we_i      (cal_we),
    .waddr_i   (addr_i[4:0]),
    .wdata_i   (wdata_i),
    .ra_i      (addr_i[4:0]),
    .rb_i      (idx_q[4:0]),
    .qa_o      (cal_qa),
    .qb_o      (cal_qb)
  );

  tts_mem #(.W(tts_pkg::PRO_W), .D(tts_pkg::NPRO), .AW(7)) u_pro (
    .clk_sys_i (clk_sys_i),
    .reset_i   (reset_i),
    .we_i      (pro_we),
    .waddr_i   (addr_i[6:0]),
    .wdata_i   (wdata_i[tts_pkg::PRO_W-1:0]),
    .ra_i      (addr_i[6:0]),
    .rb_i      (pro_rb),
    .qa_o      (pro_qa),
    .qb_o      (pro_qb)
  );

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  always_comb begin
    logic [17:0] tot;
    tot = '0;
    for (int j = 0; j < tts_pkg::NLOG; j++) begin
      tot = tot + {1'b0, log_q[j]};
    end
    cfg_d  = cfg_q;
    mult_d = mult_q;
    log_d  = log_q;
    for (int i = 0; i < tts_pkg::NREG; i++) begin
      if (wr_i && addr_i == tts_pkg::A_CFG + 8'(i) && wdata_i[tts_pkg::F_SRC +: 5] <= tts_pkg::SRC_MAX) begin
        cfg_d[i] = wdata_i[tts_pkg::CFG_W-1:0];
        if (is_int(wdata_i[tts_pkg::F_SRC +: 5])) begin
          mult_d[i] = tts_pkg::MULT_DEF;
        end
      end
      if (wr_i && addr_i == tts_pkg::A_MULT + 8'(i) && !is_int(src_of(cfg_q[i])) &&
          wdata_i >= 32'(tts_pkg::MULT_MIN) && wdata_i <= 32'(tts_pkg::MULT_MAX)) begin
        mult_d[i] = wdata_i[16:0];
      end
    end
    for (int j = 0; j < tts_pkg::NLOG; j++) begin
      if (wr_i && addr_i == tts_pkg::A_LOG + 8'(j) && wdata_i[31:17] == 15'h0000 &&
          tot - {1'b0, log_q[j]} + {1'b0, wdata_i[16:0]} <= tts_pkg::MEM_BYTES) begin
        log_d[j] = wdata_i[16:0];
      end
    end
  end

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      for (int i = 0; i < tts_pkg::NREG; i++) begin
        cfg_q[i]  <= tts_pkg::CFG_RST;
        mult_q[i] <= tts_pkg::MULT_DEF;
      end
      log_q[0] <= tts_pkg::LOG_EVT_DEF;
      log_q[1] <= tts_pkg::LOG_D1_DEF;
      log_q[2] <= tts_pkg::LOG_D2_DEF;
    end else begin
      cfg_q  <= cfg_d;
      mult_q <= mult_d;
      log_q  <= log_d;
    end
  end

  // ----------------------------------------------------------------
  // Tariff evaluation sequencer
  // ----------------------------------------------------------------
  always_comb begin
    logic [6:0] pq;
    logic [7:0] un;
    pq     = '0;
    un     = used_q;
    st_d   = st_q;
    idx_d  = idx_q;
    ph_d   = ~ph_q;
    sea_d  = sea_q;
    day_d  = day_q;
    hit_d  = hit_q;
    cand_d = cand_q;
    trf_d  = trf_q;
    used_d = used_q;
    cnt_d  = cnt_q;
    qtr_d  = qtr_q;
    evp_d  = evp_q;
    swp_d  = swp_q;
    unique case (st_q)
      tts_pkg::S_IDLE: begin
        ph_d  = 1'b0;
        idx_d = '0;
        if (swp_q) begin
          st_d   = tts_pkg::S_SWEEP;
          swp_d  = 1'b0;
          used_d = '0;
        end else if (evp_q || qtr_now != qtr_q) begin
          st_d  = tts_pkg::S_CAL;
          qtr_d = qtr_now;
          evp_d = 1'b0;
        end
      end
      tts_pkg::S_CAL: begin
        if (ph_q) begin
          if (cal_hit(cal_qb, month_i, mday_i, wday_i, wom_i)) begin
            st_d   = tts_pkg::S_PRO;
            sea_d  = cal_qb[tts_pkg::C_SEA +: 2];
            day_d  = cal_qb[tts_pkg::C_DAY +: 2];
            hit_d  = 1'b1;
            idx_d  = '0;
            cand_d = '0;
          end else if (idx_q == 7'(tts_pkg::NCAL - 1)) begin
            st_d   = tts_pkg::S_PRO;
            sea_d  = '0;
            day_d  = '0;
            hit_d  = 1'b0;
            idx_d  = '0;
            cand_d = '0;
          end else begin
            idx_d = idx_q + 7'h01;
          end
        end
      end
      tts_pkg::S_PRO: begin
        if (ph_q) begin
          pq = (idx_q[2:0] == 3'h0) ? 7'h00 : pro_qb[tts_pkg::P_QTR +: 7];
          if (pro_qb[tts_pkg::P_VAL] && pq <= qtr_q) begin
            cand_d = pro_qb[tts_pkg::P_TRF +: 3];
          end
          if (idx_q[2:0] == 3'(tts_pkg::NPT - 1)) begin
            st_d  = tts_pkg::S_IDLE;
            trf_d = (pro_qb[tts_pkg::P_VAL] && pq <= qtr_q) ? pro_qb[tts_pkg::P_TRF +: 3] : cand_q;
          end else begin
            idx_d = idx_q + 7'h01;
          end
        end
      end
      tts_pkg::S_SWEEP: begin
        if (ph_q) begin
          if (pro_qb[tts_pkg::P_VAL]) begin
            un[pro_qb[tts_pkg::P_TRF +: 3]] = 1'b1;
          end
          used_d = un;
          if (idx_q == 7'(tts_pkg::NPRO - 1)) begin
            st_d  = tts_pkg::S_IDLE;
            evp_d = 1'b1;
            cnt_d = '0;
            for (int t = 0; t < tts_pkg::NTRF; t++) begin
              cnt_d = cnt_d + 4'(un[t]);
            end
          end else begin
            idx_d = idx_q + 7'h01;
          end
        end
      end
    endcase
    if (cal_we) begin
      evp_d = 1'b1;
    end
    if (pro_we) begin
      swp_d = 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      st_q   <= tts_pkg::S_IDLE;
      idx_q  <= '0;
      ph_q   <= 1'b0;
      sea_q  <= '0;
      day_q  <= '0;
      hit_q  <= 1'b0;
      cand_q <= '0;
      trf_q  <= '0;
      used_q <= '0;
      cnt_q  <= '0;
      qtr_q  <= '0;
      evp_q  <= 1'b1;
      swp_q  <= 1'b0;
    end else begin
      st_q   <= st_d;
      idx_q  <= idx_d;
      ph_q   <= ph_d;
      sea_q  <= sea_d;
      day_q  <= day_d;
      hit_q  <= hit_d;
      cand_q <= cand_d;
      trf_q  <= trf_d;
      used_q <= used_d;
      cnt_q  <= cnt_d;
      qtr_q  <= qtr_d;
      evp_q  <= evp_d;
      swp_q  <= swp_d;
    end
  end

  // ----------------------------------------------------------------
  // Pulse steering, log selection and read data
  // ----------------------------------------------------------------
  always_comb begin
    logic [1:0] n;
    logic       anytou;
    logic       p;
    logic [4:0] s;
    p      = 1'b0;
    s      = '0;
    n      = '0;
    anytou = 1'b0;
    tot_d  = '0;
    tou_d  = '0;
    le_d   = '0;
    ld_d   = '0;
    ls_d   = '0;
    rd_d   = '0;
    scal_d = rd_i && (addr_i[7:5] == tts_pkg::A_CAL3);
    spro_d = rd_i && addr_i[7];
    for (int i = 0; i < tts_pkg::NREG; i++) begin
      s      = src_of(cfg_q[i]);
      tgt[i] = n;
      if (s != tts_pkg::SRC_NONE) begin
        n = n + 2'h1;
      end
      p = is_int(s) ? energy_pulse_i[3'(s - 5'h01)] :
          (s >= tts_pkg::SRC_DI1) ? pulse_digital_inputs_i[4'(s - tts_pkg::SRC_DI1)] : 1'b0;
      tot_d[tgt[i]] = tot_d[tgt[i]] | p;
      tou_d[tgt[i]] = tou_d[tgt[i]] | (p & cfg_q[i][tts_pkg::F_TOU]);
      anytou = anytou | cfg_q[i][tts_pkg::F_TOU];
      le_d[i] = cfg_q[i][tts_pkg::F_USE] && s != tts_pkg::SRC_NONE;
      ld_d[i] = cfg_q[i][tts_pkg::F_DMD] && s != tts_pkg::SRC_NONE;
      ls_d[i] = cfg_q[i][tts_pkg::F_SUM] && s != tts_pkg::SRC_NONE;
      if (rd_i && addr_i == tts_pkg::A_CFG + 8'(i)) begin
        rd_d = {18'h00000, tgt[i], unit_of(cfg_q[i]), cfg_q[i][8:0]};
      end
      if (rd_i && addr_i == tts_pkg::A_MULT + 8'(i)) begin
        rd_d = {15'h0000, mult_q[i]};
      end
    end
    lt_d = anytou ? cnt_q : 4'h0;
    for (int j = 0; j < tts_pkg::NLOG; j++) begin
      if (rd_i && addr_i == tts_pkg::A_LOG + 8'(j)) begin
        rd_d = {15'h0000, log_q[j]};
      end
    end
    if (rd_i && addr_i == tts_pkg::A_STAT) begin
      rd_d = {19'h00000, st_q != tts_pkg::S_IDLE, cnt_q, hit_q, day_q, sea_q, trf_q};
    end
  end

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      rd_q          <= '0;
      scal_q        <= 1'b0;
      spro_q        <= 1'b0;
      tot_pulse_o   <= '0;
      tou_pulse_o   <= '0;
      tariff_o      <= '0;
      season_o      <= '0;
      day_type_o    <= '0;
      log_energy_o  <= '0;
      log_demand_o  <= '0;
      log_summary_o <= '0;
      log_tariffs_o <= '0;
    end else begin
      rd_q          <= rd_d;
      scal_q        <= scal_d;
      spro_q        <= spro_d;
      tot_pulse_o   <= tot_d;
      tou_pulse_o   <= tou_d;
      tariff_o      <= trf_q;
      season_o      <= sea_q;
      day_type_o    <= day_q;
      log_energy_o  <= le_d;
      log_demand_o  <= ld_d;
      log_summary_o <= ls_d;
      log_tariffs_o <= lt_d;
    end
  end
endmodule

// File: dv/tts_asserts.sv
/* Port checker for tts_top: pulse steering, read port, evaluation hold.
   Assumes it is bound to tts_top; one clock, async active-high reset. */
`timescale 1ns/1ps
module tts_asserts (
  input wire logic        clk_sys_i,
  input wire logic        reset_i,
  input wire logic        wr_i,
  input wire logic        rd_i,
  input wire logic [31:0] rdata_o,
  input wire logic [3:0]  month_i,
  input wire logic [4:0]  hour_i,
  input wire logic [5:0]  minute_i,
  input wire logic [4:0]  energy_pulse_i,
  input wire logic [11:0] pulse_digital_inputs_i,
  input wire logic [3:0]  tot_pulse_o,
  input wire logic [3:0]  tou_pulse_o,
  input wire logic [2:0]  tariff_o,
  input wire logic [1:0]  season_o,
  input wire logic [1:0]  day_type_o,
  input wire logic [3:0]  log_tariffs_o
);
  logic [8:0] quiet_q;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);
  // Cycles since the last write or month, hour or minute change
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) quiet_q <= 9'h000;
    else if (wr_i || $changed({month_i, hour_i, minute_i})) quiet_q <= 9'h000;
    else if (quiet_q != 9'h1FF) quiet_q <= quiet_q + 9'h001;
  end
  chk_tou_subset: assert property ((tou_pulse_o & ~tot_pulse_o) == 4'h0)
    else $error("tariff pulse without total pulse");
  chk_pulse_cause: assert property (|tot_pulse_o |-> $past(|{energy_pulse_i, pulse_digital_inputs_i}))
    else $error("total pulse without source pulse");
  chk_pulse_slot: assert property ($onehot0({energy_pulse_i, pulse_digital_inputs_i}) |=> $onehot0(tot_pulse_o))
    else $error("one source pulse reached two slots");
  chk_read_idle: assert property (!rd_i |=> rdata_o == 32'h0)
    else $error("read data outside read cycle");
  chk_tariff_hold: assert property (quiet_q == 9'h1FF |-> $stable(tariff_o))
    else $error("tariff changed with no cause");
  chk_season_hold: assert property (quiet_q == 9'h1FF |-> $stable({season_o, day_type_o}))
    else $error("season changed with no cause");
  chk_tariff_count: assert property (log_tariffs_o <= 4'h8)
    else $error("tariff count above eight");
  chk_reset_quiet: assert property ($past(reset_i) |-> (tot_pulse_o | tou_pulse_o) == 4'h0)
    else $error("pulse right after reset");
  cover property (|tou_pulse_o);
  cover property ($changed(tariff_o));
  cover property ($changed(season_o));
endmodule
bind tts_top tts_asserts u_chk (.clk_sys_i, .reset_i, .wr_i, .rd_i, .rdata_o, .month_i, .hour_i, .minute_i,
  .energy_pulse_i, .pulse_digital_inputs_i, .tot_pulse_o, .tou_pulse_o, .tariff_o, .season_o, .day_type_o,
  .log_tariffs_o);

// File: dv/tts_top_tb.sv
/* Testbench for tts_top: registers, pulse steering, calendar and profiles.
   Assumes the checker binds itself from its own file. */
`timescale 1ns/1ps
module tts_top_tb;
  logic        clk_sys_i, reset_i, wr_i, rd_i;
  logic [7:0]  addr_i;
  logic [31:0] wdata_i, rdata_o;
  logic [3:0]  month_i, tot_pulse_o, tou_pulse_o, log_energy_o, log_demand_o, log_summary_o, log_tariffs_o;
  logic [4:0]  mday_i, hour_i, energy_pulse_i;
  logic [2:0]  wday_i, wom_i, tariff_o;
  logic [5:0]  minute_i;
  logic [11:0] pulse_digital_inputs_i;
  logic [1:0]  season_o, day_type_o;
  int          err_count = 0;
  int          check_count = 0;
  tts_top uut (.clk_sys_i, .reset_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .month_i, .mday_i, .wday_i,
    .wom_i, .hour_i, .minute_i, .energy_pulse_i, .pulse_digital_inputs_i, .tot_pulse_o, .tou_pulse_o, .tariff_o,
    .season_o, .day_type_o, .log_energy_o, .log_demand_o, .log_summary_o, .log_tariffs_o);
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clk_sys_i);
    wr_i    <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_sys_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_sys_i);
    rd_i   <= 1'b0;
    @(negedge clk_sys_i);
    chk("rdata", e, rdata_o);
  endtask
  task automatic pulse(input logic [4:0] e, input logic [11:0] d, input logic [3:0] et, input logic [3:0] eu);
    @(posedge clk_sys_i);
    energy_pulse_i         <= e;
    pulse_digital_inputs_i <= d;
    @(posedge clk_sys_i);
    energy_pulse_i         <= 5'h00;
    pulse_digital_inputs_i <= 12'h000;
    @(negedge clk_sys_i);
    chk("tot_pulse", {28'h0, et}, {28'h0, tot_pulse_o});
    chk("tou_pulse", {28'h0, eu}, {28'h0, tou_pulse_o});
  endtask
  task automatic settime(input logic [3:0] m, input logic [4:0] h, input logic [5:0] mi);
    @(posedge clk_sys_i);
    month_i  <= m;
    hour_i   <= h;
    minute_i <= mi;
    repeat (600) @(posedge clk_sys_i);
  endtask
  task automatic test_defaults;
    rd(8'h00, 32'h0000000A);
    rd(8'h04, 32'h000003E8);
    rd(8'h08, 32'h00000C80);
    rd(8'h09, 32'h00019500);
    rd(8'h0A, 32'h000021C0);
    rd(8'h40, 32'h00000000);
    $display("test_defaults done");
  endtask
  task automatic test_links;
    for (int s = 1; s < 6; s++) begin
      wr(8'h00, 32'((s << 4) | 1));
      rd(8'h00, 32'(((s < 3 ? 1 : s < 5 ? 2 : 3) << 9) | (s << 4) | 1));
      pulse(5'(1 << (s - 1)), 12'h000, 4'h1, 4'h1);
    end
    for (int k = 0; k < 12; k++) begin
      wr(8'h01, 32'(((6 + k) << 4) | 'h808));
      pulse(5'h00, 12'(1 << k), 4'h2, 4'h0);
    end
    wr(8'h00, 32'h00000017);
    wr(8'h02, 32'h00000120);
    rd(8'h00, 32'h00000217);
    rd(8'h01, 32'h00001918);
    rd(8'h02, 32'h0000200A);
    wr(8'h04, 32'h00000005);
    rd(8'h04, 32'h000003E8);
    wr(8'h05, 32'h000186A1);
    rd(8'h05, 32'h000003E8);
    wr(8'h05, 32'h000186A0);
    rd(8'h05, 32'h000186A0);
    chk("log_energy", 32'h1, {28'h0, log_energy_o});
    chk("log_summary", 32'h2, {28'h0, log_summary_o});
    chk("log_demand", 32'h1, {28'h0, log_demand_o});
    wr(8'h0A, 32'h00005281);
    rd(8'h0A, 32'h000021C0);
    wr(8'h0A, 32'h00005280);
    rd(8'h0A, 32'h00005280);
    $display("test_links done");
  endtask
  task automatic test_tariffs;
    wr(8'hA0, 32'h00000402);
    wr(8'hA1, 32'h00000545);
    wr(8'h40, 32'h06408600);
    wr(8'h41, 32'h05000000);
    rd(8'h40, 32'h06408600);
    rd(8'hA1, 32'h00000545);
    settime(4'd7, 5'd9, 6'd0);
    chk("season", 32'h2, {30'h0, season_o});
    chk("day_type", 32'h1, {30'h0, day_type_o});
    settime(4'd9, 5'd9, 6'd15);
    chk("season", 32'h1, {30'h0, season_o});
    chk("tariff", 32'h2, {29'h0, tariff_o});
    settime(4'd9, 5'd10, 6'd0);
    chk("tariff", 32'h5, {29'h0, tariff_o});
    settime(4'd9, 5'd23, 6'd45);
    chk("tariff", 32'h5, {29'h0, tariff_o});
    chk("log_tariffs", 32'h2, {28'h0, log_tariffs_o});
    rd(8'h0C, 32'h0000028D);
    $display("test_tariffs done");
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    clk_sys_i = 1'b0;
    forever #50 clk_sys_i = ~clk_sys_i;
  end
  initial begin
    {reset_i, wr_i, rd_i, addr_i, wdata_i} = {3'b100, 40'h0};
    {energy_pulse_i, pulse_digital_inputs_i, hour_i, minute_i} = 28'h0;
    {month_i, mday_i, wday_i, wom_i} = {4'd1, 5'd1, 3'd1, 3'd1};
    repeat (12) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    test_defaults;
    test_links;
    test_tariffs;
    complete_run;
  end
  initial begin
    #1000000;
    err_count++;
    complete_run;
  end
endmodule
